//--- verilog/line_rx_pkg.sv
// constants shared by the serial line receiver and its transmit fifo
// assumes one system clock; link clocks arrive as plain sampled inputs
// Notes on behaviour
// - setting sync search starts comparing incoming bits with the sync char
// - one or two contiguous sync chars select sync; two by default
// - lone sync in two-sync mode resets receive logic, ignores two bits
// - after sync, receiver active sets; chars request interrupts if enabled
// - clearing sync search loses the partial char and drops sync
// - stripping hides the done interrupt of sync chars but keeps them
// - unread buffer is overwritten by the next char, overrun sets
// - one-sync mode resyncs falsely if a sync char sits in the buffer
// - external mode goes active at once, framing from the next bit
// - full char moves into the buffer, sets done and requests interrupt
// - isochronous transmit needs no sync char, idles between chars
// - isochronous transmit wraps each char in start and stop bits
// - transmit done sets on first data bit, holds until rewrite or disable
// - isochronous receive goes active at once, frames on a start bit
// - isochronous receive checks stop bit, stores bare char, sets done
// - missing stop bit also sets the framing error flag
// - after reset or master reset the sync char is all ones
// - one-sync switch on selects one sync char, off selects two
package line_rx_pkg;
	// ****************************************
	// modes and widths
	// ****************************************
	localparam logic [1:0] MODE_INT_SYNC = 2'h0;
	localparam logic [1:0] MODE_EXT_SYNC = 2'h1;
	localparam logic [1:0] MODE_ISO = 2'h2;
	localparam int DATA_WIDTH = 8;
	localparam int FIFO_DEPTH = 8;
	localparam logic [3:0] CHAR_LEN_BASE = 4'h5;
	localparam logic [3:0] HOLDOFF_BITS = 4'h2;
	// ****************************************
	// line levels and reset values
	// ****************************************
	localparam logic START_LEVEL = 1'b0;
	localparam logic MARK_LEVEL = 1'b1;
	localparam logic SYNC_RESET_BIT = 1'b1;
endpackage : line_rx_pkg

//--- verilog/stream_if.sv
// valid/ready word channel between the line block and its fifo
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface stream_if #(parameter int WIDTH = 8);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : stream_if

//--- verilog/word_fifo.sv
// synchronous word fifo with valid/ready on both sides
// assumes synchronous active low reset on the same clock
`timescale 1ns/100ps
module word_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	stream_if.snk wr,
	stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_depth
		$error("word_fifo: depth must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp;
	logic [AW:0] rp;
	wire full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
	wire empty = (wp == rp);
	wire push = wr.valid && !full;
	wire pop = rd.ready && !empty;
	assign wr.ready = !full;
	assign rd.valid = !empty;
	assign rd.data = mem[rp[AW-1:0]];
	always_ff @(posedge clk) begin
		if (push)
			mem[wp[AW-1:0]] <= wr.data;
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wp <= '0;
			rp <= '0;
		end else begin
			wp <= wp + (AW+1)'(push);
			rp <= rp + (AW+1)'(pop);
		end
	end
endmodule : word_fifo

//--- verilog/sync_iso_line_receiver.sv
// serial receiver with sync search and isochronous transmitter
// assumes link clocks and data are asynchronous pins; control from same clock
`timescale 1ns/100ps
module sync_iso_line_receiver #(
	parameter int DATA_W = line_rx_pkg::DATA_WIDTH,
	parameter int TX_DEPTH = line_rx_pkg::FIFO_DEPTH
) (
	input wire logic SYS_CLK,
	input wire logic RESETN,
	input wire logic MASTER_RESET_PULSE,
	input wire logic [1:0] LINE_MODE,
	input wire logic [1:0] CHAR_LENGTH,
	input wire logic ONE_SYNC_SWITCH,
	input wire logic SYNC_SEARCH_ENABLE,
	input wire logic DISCARD_SYNC_CHARS,
	input wire logic RX_IRQ_ENABLE,
	input wire logic SYNC_CHAR_WRITE,
	input wire logic [DATA_W-1:0] SYNC_CHAR_WDATA,
	input wire logic RX_BUFFER_READ,
	input wire logic RX_LINK_CLK,
	input wire logic RX_LINE_DATA,
	input wire logic TX_LINK_CLK,
	input wire logic TX_ENABLE,
	input wire logic TX_IRQ_ENABLE,
	input wire logic TX_BUFFER_WRITE,
	input wire logic [DATA_W-1:0] TX_BUFFER_WDATA,
	output logic TX_BUFFER_READY,
	output logic TX_LINE_DATA,
	output logic TX_DONE,
	output logic TX_IRQ,
	output logic [DATA_W-1:0] RX_DATA_BUFFER,
	output logic [DATA_W-1:0] SYNC_CHAR,
	output logic RECEIVER_ACTIVE,
	output logic RX_DONE,
	output logic OVERRUN_ERROR,
	output logic FRAMING_ERROR,
	output logic RX_IRQ
);
	if (DATA_W < 8 || DATA_W > 15) begin : g_bad_width
		$error("line receiver: data width must be 8 to 15");
	end

	// ****************************************
	// helpers
	// ****************************************
	localparam logic [3:0] W4 = 4'(DATA_W);

	// align a right-shifting assembly register to the char length
	function automatic logic [DATA_W-1:0] frame(
		input logic [DATA_W-1:0] sh,
		input logic [3:0] n
	);
		frame = sh >> (W4 - n);
	endfunction : frame

	function automatic logic [DATA_W-1:0] char_mask(input logic [3:0] n);
		char_mask = {DATA_W{1'b1}} >> (W4 - n);
	endfunction : char_mask

	typedef enum {
		R_IDLE, R_HUNT, R_SECOND, R_HOLDOFF, R_ACTIVE,
		R_ISO_WAIT, R_ISO_DATA, R_ISO_STOP
	} rx_state_t;
	typedef enum {T_IDLE, T_START, T_BITS, T_STOP} tx_state_t;

	// master reset acts like a second, program driven, init
	wire rst_n = RESETN && !MASTER_RESET_PULSE;
	wire [3:0] len = line_rx_pkg::CHAR_LEN_BASE + {2'h0, CHAR_LENGTH};
	wire iso = (LINE_MODE == line_rx_pkg::MODE_ISO);
	wire ext = (LINE_MODE == line_rx_pkg::MODE_EXT_SYNC);

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic rx_clk_s1, rx_clk_s2, rx_clk_prev;
	logic rx_dat_s1, rx_dat_s2;
	logic tx_clk_s1, tx_clk_s2, tx_clk_prev;
	always_ff @(posedge SYS_CLK) begin
		if (!rst_n) begin
			rx_clk_s1 <= 1'b0;
			rx_clk_s2 <= 1'b0;
			rx_clk_prev <= 1'b0;
			rx_dat_s1 <= line_rx_pkg::MARK_LEVEL;
			rx_dat_s2 <= line_rx_pkg::MARK_LEVEL;
			tx_clk_s1 <= 1'b0;
			tx_clk_s2 <= 1'b0;
			tx_clk_prev <= 1'b0;
		end else begin
			rx_clk_s1 <= RX_LINK_CLK;
			rx_clk_s2 <= rx_clk_s1;
			rx_clk_prev <= rx_clk_s2;
			rx_dat_s1 <= RX_LINE_DATA;
			rx_dat_s2 <= rx_dat_s1;
			tx_clk_s1 <= TX_LINK_CLK;
			tx_clk_s2 <= tx_clk_s1;
			tx_clk_prev <= tx_clk_s2;
		end
	end
	// receive samples on rising edge, transmit changes on falling edge
	wire rx_edge = rx_clk_s2 && !rx_clk_prev;
	wire tx_fall = !tx_clk_s2 && tx_clk_prev;
	wire rx_bit = rx_dat_s2;

	// ****************************************
	// sync character register
	// ****************************************
	always_ff @(posedge SYS_CLK) begin
		if (!rst_n)
			SYNC_CHAR <= {DATA_W{line_rx_pkg::SYNC_RESET_BIT}};
		else if (SYNC_CHAR_WRITE)
			SYNC_CHAR <= SYNC_CHAR_WDATA;
	end

	// ****************************************
	// receive framing
	// ****************************************
	rx_state_t rstate, next_rstate;
	logic [DATA_W-1:0] shreg, next_shreg;
	logic [3:0] bits, next_bits;
	logic store, store_ferr, store_sync;
	logic [DATA_W-1:0] store_data;
	logic buf_sync;

	wire [DATA_W-1:0] shifted = {rx_bit, shreg[DATA_W-1:1]};
	wire [DATA_W-1:0] char_now = frame(shifted, len);
	wire [DATA_W-1:0] sync_ref = SYNC_CHAR & char_mask(len);
	wire sync_hit = (char_now == sync_ref);
	wire [3:0] bits_inc = bits + 4'h1;
	wire char_end = (bits_inc == len);
	// a sync char left in the buffer fools a one-sync restart
	wire stale_sync = ONE_SYNC_SWITCH &&
		((RX_DATA_BUFFER & char_mask(len)) == sync_ref);

	always_comb begin
		next_rstate = rstate;
		next_shreg = shreg;
		next_bits = bits;
		store = 1'b0;
		store_ferr = 1'b0;
		store_sync = 1'b0;
		store_data = char_now;
		if (!SYNC_SEARCH_ENABLE) begin
			next_rstate = R_IDLE;
			next_bits = 4'h0;
		end else begin
			case (rstate)
				R_IDLE: begin
					next_bits = 4'h0;
					next_shreg = '0;
					if (ext)
						next_rstate = R_ACTIVE;
					else if (iso)
						next_rstate = R_ISO_WAIT;
					else if (stale_sync)
						next_rstate = R_ACTIVE;
					else
						next_rstate = R_HUNT;
				end
				R_HUNT: if (rx_edge) begin
					next_shreg = shifted;
					next_bits = 4'h0;
					if (sync_hit)
						next_rstate = ONE_SYNC_SWITCH ? R_ACTIVE : R_SECOND;
				end
				R_SECOND: if (rx_edge) begin
					next_shreg = shifted;
					next_bits = bits_inc;
					if (char_end) begin
						next_bits = 4'h0;
						next_rstate = sync_hit ? R_ACTIVE : R_HOLDOFF;
					end
				end
				R_HOLDOFF: if (rx_edge) begin
					// bits are ignored here; a sync starting now is missed
					next_bits = bits_inc;
					if (bits_inc == line_rx_pkg::HOLDOFF_BITS) begin
						next_bits = 4'h0;
						next_shreg = '0;
						next_rstate = R_HUNT;
					end
				end
				R_ACTIVE: if (rx_edge) begin
					next_shreg = shifted;
					next_bits = bits_inc;
					if (char_end) begin
						next_bits = 4'h0;
						store = 1'b1;
						store_sync = sync_hit;
					end
				end
				R_ISO_WAIT: if (rx_edge && rx_bit == line_rx_pkg::START_LEVEL) begin
					next_bits = 4'h0;
					next_shreg = '0;
					next_rstate = R_ISO_DATA;
				end
				R_ISO_DATA: if (rx_edge) begin
					next_shreg = shifted;
					next_bits = bits_inc;
					if (char_end)
						next_rstate = R_ISO_STOP;
				end
				R_ISO_STOP: if (rx_edge) begin
					store = 1'b1;
					store_data = frame(shreg, len);
					store_ferr = (rx_bit != line_rx_pkg::MARK_LEVEL);
					next_bits = 4'h0;
					next_rstate = R_ISO_WAIT;
				end
				default: next_rstate = R_IDLE;
			endcase
		end
	end

	wire next_active = (next_rstate == R_ACTIVE) ||
		(next_rstate == R_ISO_WAIT) || (next_rstate == R_ISO_DATA) ||
		(next_rstate == R_ISO_STOP);

	always_ff @(posedge SYS_CLK) begin
		if (!rst_n) begin
			rstate <= R_IDLE;
			shreg <= '0;
			bits <= 4'h0;
			RECEIVER_ACTIVE <= 1'b0;
		end else begin
			rstate <= next_rstate;
			shreg <= next_shreg;
			bits <= next_bits;
			RECEIVER_ACTIVE <= next_active;
		end
	end

	// ****************************************
	// receive buffer and flags
	// ****************************************
	// a read in the same cycle as a new char does not clear it
	wire next_done = store || (RX_DONE && !RX_BUFFER_READ);
	wire next_ovr = (store && RX_DONE && !RX_BUFFER_READ) ||
		(OVERRUN_ERROR && !RX_BUFFER_READ);
	wire next_ferr = (store && store_ferr) ||
		(FRAMING_ERROR && !RX_BUFFER_READ);

	always_ff @(posedge SYS_CLK) begin
		if (!rst_n) begin
			RX_DATA_BUFFER <= '0;
			buf_sync <= 1'b0;
			RX_DONE <= 1'b0;
			OVERRUN_ERROR <= 1'b0;
			FRAMING_ERROR <= 1'b0;
		end else begin
			if (store) begin
				RX_DATA_BUFFER <= store_data;
				buf_sync <= store_sync;
			end
			RX_DONE <= next_done;
			OVERRUN_ERROR <= next_ovr;
			FRAMING_ERROR <= next_ferr;
		end
	end
	assign RX_IRQ = RX_DONE && RX_IRQ_ENABLE &&
		!(DISCARD_SYNC_CHARS && buf_sync);

	// ****************************************
	// transmit buffer
	// ****************************************
	stream_if #(.WIDTH(DATA_W)) tx_in ();
	stream_if #(.WIDTH(DATA_W)) tx_out ();
	word_fifo #(.WIDTH(DATA_W), .DEPTH(TX_DEPTH)) u_word_fifo (
		.clk(SYS_CLK),
		.rst_n(rst_n),
		.wr(tx_in),
		.rd(tx_out)
	);
	assign tx_in.valid = TX_BUFFER_WRITE;
	assign tx_in.data = TX_BUFFER_WDATA;
	assign TX_BUFFER_READY = tx_in.ready;
	wire tx_written = TX_BUFFER_WRITE && tx_in.ready;

	// ****************************************
	// isochronous transmitter
	// ****************************************
	tx_state_t tstate, next_tstate;
	logic [DATA_W-1:0] tsh;
	logic [3:0] tbits;
	// no sync fill: the line simply marks when the fifo is empty
	wire tx_take = (tstate == T_IDLE) && iso && TX_ENABLE;
	assign tx_out.ready = tx_take;
	wire tx_load = tx_take && tx_out.valid;
	wire tx_first = (tstate == T_BITS) && tx_fall && (tbits == 4'h0);
	wire tbits_end = ((tbits + 4'h1) == len);

	always_comb begin
		next_tstate = tstate;
		case (tstate)
			T_IDLE: if (tx_load) next_tstate = T_START;
			T_START: if (tx_fall) next_tstate = T_BITS;
			T_BITS: if (tx_fall && tbits_end) next_tstate = T_STOP;
			T_STOP: if (tx_fall) next_tstate = T_IDLE;
			default: next_tstate = T_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (!rst_n) begin
			tstate <= T_IDLE;
			tsh <= '0;
			tbits <= 4'h0;
			TX_LINE_DATA <= line_rx_pkg::MARK_LEVEL;
		end else begin
			tstate <= next_tstate;
			if (tx_load) begin
				tsh <= tx_out.data;
				tbits <= 4'h0;
			end
			if (tx_fall) begin
				case (tstate)
					T_START: TX_LINE_DATA <= line_rx_pkg::START_LEVEL;
					T_BITS: begin
						TX_LINE_DATA <= tsh[0];
						tsh <= {1'b0, tsh[DATA_W-1:1]};
						tbits <= tbits + 4'h1;
					end
					default: TX_LINE_DATA <= line_rx_pkg::MARK_LEVEL;
				endcase
			end
		end
	end

	// first data bit on the line wins over a same cycle rewrite
	always_ff @(posedge SYS_CLK) begin
		if (!rst_n)
			TX_DONE <= 1'b0;
		else
			TX_DONE <= tx_first ||
				(TX_DONE && !tx_written && TX_ENABLE);
	end
	assign TX_IRQ = TX_DONE && TX_IRQ_ENABLE;
endmodule : sync_iso_line_receiver

//--- testbench/line_rx_monitor.sv
// checker on the line receiver ports
// assumes it is bound onto every receiver instance
`timescale 1ns/100ps
module line_rx_monitor #(
	parameter int DATA_W = 8
) (
	input wire logic SYS_CLK,
	input wire logic RESETN,
	input wire logic MASTER_RESET_PULSE,
	input wire logic [1:0] LINE_MODE,
	input wire logic SYNC_SEARCH_ENABLE,
	input wire logic DISCARD_SYNC_CHARS,
	input wire logic RX_IRQ_ENABLE,
	input wire logic RX_BUFFER_READ,
	input wire logic TX_IRQ_ENABLE,
	input wire logic TX_DONE,
	input wire logic TX_IRQ,
	input wire logic [DATA_W-1:0] RX_DATA_BUFFER,
	input wire logic [DATA_W-1:0] SYNC_CHAR,
	input wire logic RECEIVER_ACTIVE,
	input wire logic RX_DONE,
	input wire logic OVERRUN_ERROR,
	input wire logic FRAMING_ERROR,
	input wire logic RX_IRQ
);
	// ****************************************
	// properties
	// ****************************************
	wire in_reset = !RESETN || MASTER_RESET_PULSE;
	wire frame_mode = LINE_MODE == line_rx_pkg::MODE_EXT_SYNC
		|| LINE_MODE == line_rx_pkg::MODE_ISO;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (in_reset);
	// reset itself is the cause here, so it must not disable
	reset_clear_a: assert property (disable iff (1'b0)
		in_reset |=> !RECEIVER_ACTIVE && !RX_DONE && !OVERRUN_ERROR
		&& !FRAMING_ERROR && SYNC_CHAR == '1)
		else $error("reset left a flag or sync char");
	search_off_a: assert property (
		!SYNC_SEARCH_ENABLE |=> !RECEIVER_ACTIVE)
		else $error("active without search");
	early_active_a: assert property (
		$rose(SYNC_SEARCH_ENABLE) && frame_mode |-> ##[1:2] RECEIVER_ACTIVE)
		else $error("framing mode not active at once");
	done_active_a: assert property (
		$rose(RX_DONE) |-> $past(RECEIVER_ACTIVE))
		else $error("char done while not active");
	irq_open_a: assert property (
		RX_DONE && RX_IRQ_ENABLE && !DISCARD_SYNC_CHARS |-> RX_IRQ)
		else $error("rx irq missing");
	strip_mask_a: assert property (
		RX_DONE && DISCARD_SYNC_CHARS && RX_DATA_BUFFER == SYNC_CHAR
		|-> !RX_IRQ)
		else $error("stripped sync raised irq");
	done_hold_a: assert property (
		RX_DONE && !RX_BUFFER_READ |=> RX_DONE)
		else $error("rx done lost before read");
	overrun_cause_a: assert property (
		$rose(OVERRUN_ERROR) |-> $past(RX_DONE) && RX_DONE)
		else $error("overrun without held char");
	read_clear_a: assert property (
		RX_BUFFER_READ |=> !OVERRUN_ERROR)
		else $error("overrun kept after read");
	frame_err_a: assert property (
		$rose(FRAMING_ERROR) |-> RX_DONE
		&& LINE_MODE == line_rx_pkg::MODE_ISO)
		else $error("framing error out of place");
	tx_irq_a: assert property (
		TX_IRQ == (TX_DONE && TX_IRQ_ENABLE))
		else $error("tx irq wrong");
	cover property ($rose(OVERRUN_ERROR));
	cover property ($rose(FRAMING_ERROR));
	cover property ($rose(TX_DONE));
endmodule : line_rx_monitor
bind sync_iso_line_receiver line_rx_monitor #(.DATA_W(DATA_W)) u_mon (
	.SYS_CLK(SYS_CLK), .RESETN(RESETN),
	.MASTER_RESET_PULSE(MASTER_RESET_PULSE), .LINE_MODE(LINE_MODE),
	.SYNC_SEARCH_ENABLE(SYNC_SEARCH_ENABLE),
	.DISCARD_SYNC_CHARS(DISCARD_SYNC_CHARS),
	.RX_IRQ_ENABLE(RX_IRQ_ENABLE), .RX_BUFFER_READ(RX_BUFFER_READ),
	.TX_IRQ_ENABLE(TX_IRQ_ENABLE), .TX_DONE(TX_DONE), .TX_IRQ(TX_IRQ),
	.RX_DATA_BUFFER(RX_DATA_BUFFER), .SYNC_CHAR(SYNC_CHAR),
	.RECEIVER_ACTIVE(RECEIVER_ACTIVE), .RX_DONE(RX_DONE),
	.OVERRUN_ERROR(OVERRUN_ERROR), .FRAMING_ERROR(FRAMING_ERROR),
	.RX_IRQ(RX_IRQ)
);

//--- testbench/line_partner.sv
// modem model: bit clocks and serial data on both links
// assumes an 80 ns bit period; the bench calls its tasks
`timescale 1ns/100ps
module line_partner (
	output logic rx_clk,
	output logic rx_dat,
	output logic tx_clk,
	input wire logic tx_dat,
	input wire logic tx_run
);
	// ****************************************
	// link clocks and frames
	// ****************************************
	initial rx_clk = 1'b0;
	initial rx_dat = 1'b1;
	initial tx_clk = 1'b0;
	// clock stands still low when no traffic is due
	always #40 tx_clk = tx_run ? ~tx_clk : 1'b0;
	// lsb first; line back to mark so no false start bit
	task automatic send(input logic [31:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			rx_dat = v[i];
			#40 rx_clk = 1'b1;
			#40 rx_clk = 1'b0;
		end
		rx_dat = 1'b1;
	endtask : send
	// start, n bits, stop; sampled on rising edges
	task automatic grab(input int n, output logic [7:0] c,
		output logic stp);
		c = 8'h00;
		@(posedge tx_clk iff tx_dat == 1'b0);
		for (int i = 0; i < n; i++) begin
			@(posedge tx_clk);
			c[i] = tx_dat;
		end
		@(posedge tx_clk);
		stp = tx_dat;
	endtask : grab
endmodule : line_partner

//--- testbench/test_sync_iso_line_receiver.sv
// self-checking bench for the sync/iso line receiver
// assumes the modem model and the bound checker
`timescale 1ns/100ps
module test_sync_iso_line_receiver;
	// ****************************************
	// signals and instances
	// ****************************************
	logic clk = 1'b0, rst_n = 1'b0, mrst = 1'b0, one = 1'b0, srch = 1'b0;
	logic disc = 1'b0, rxie = 1'b1, swr = 1'b0, rd = 1'b0, txen = 1'b0;
	logic txie = 1'b0, twr = 1'b0, run = 1'b0;
	logic [1:0] mode = 2'h0, clen = 2'h3;
	logic [7:0] swd = 8'h00, twd = 8'h00, rbuf, sch, c;
	logic rlc, rld, tlc, trdy, txd, tdone, tirq, act, rdone, ovr, fe, rirq;
	logic stp;
	int error_cnt = 0, tests_run = 0, k, n = 0;
	always #5 clk = ~clk;
	sync_iso_line_receiver u_sync_iso_line_receiver (
		.SYS_CLK(clk), .RESETN(rst_n), .MASTER_RESET_PULSE(mrst),
		.LINE_MODE(mode), .CHAR_LENGTH(clen), .ONE_SYNC_SWITCH(one),
		.SYNC_SEARCH_ENABLE(srch), .DISCARD_SYNC_CHARS(disc),
		.RX_IRQ_ENABLE(rxie), .SYNC_CHAR_WRITE(swr), .SYNC_CHAR_WDATA(swd),
		.RX_BUFFER_READ(rd), .RX_LINK_CLK(rlc), .RX_LINE_DATA(rld),
		.TX_LINK_CLK(tlc), .TX_ENABLE(txen), .TX_IRQ_ENABLE(txie),
		.TX_BUFFER_WRITE(twr), .TX_BUFFER_WDATA(twd),
		.TX_BUFFER_READY(trdy), .TX_LINE_DATA(txd), .TX_DONE(tdone),
		.TX_IRQ(tirq), .RX_DATA_BUFFER(rbuf), .SYNC_CHAR(sch),
		.RECEIVER_ACTIVE(act), .RX_DONE(rdone), .OVERRUN_ERROR(ovr),
		.FRAMING_ERROR(fe), .RX_IRQ(rirq)
	);
	line_partner u_p (.rx_clk(rlc), .rx_dat(rld), .tx_clk(tlc),
		.tx_dat(txd), .tx_run(run));
	// ****************************************
	// tasks
	// ****************************************
	task automatic step(input int m = 1);
		repeat (m) @(posedge clk);
		#1;
	endtask : step
	task automatic chk(input string nm, input logic [7:0] s, e);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h saw %h", nm, e, s);
		end
	endtask : chk
	task automatic rx(input logic [31:0] v, input int m);
		u_p.send(v, m);
		step(2);
	endtask : rx
	task automatic rdp();
		rd = 1'b1;
		step();
		rd = 1'b0;
	endtask : rdp
	task automatic toggle();
		srch = 1'b0;
		step(2);
		srch = 1'b1;
		step(3);
	endtask : toggle
	task end_of_test();
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test
	// ****************************************
	// sequence
	// ****************************************
	// run needs about 20 us; a wide margin avoids false hangs
	initial begin
		#400000;
		error_cnt++;
		end_of_test();
	end
	initial begin
		step(5);
		rst_n = 1'b1;
		step(3);
		chk("sync", sch, 8'hFF);
		chk("act", act, 1'b0);
		swd = 8'h96;
		swr = 1'b1;
		step();
		swr = 1'b0;
		chk("sync", sch, 8'h96);
		srch = 1'b1;
		step();
		rx({8'h00, 8'h96}, 16);
		chk("lone", act, 1'b0);
		rx({8'hA5, 8'h96, 8'h96, 2'b11}, 26);
		chk("act", act, 1'b1);
		chk("buf", rbuf, 8'hA5);
		chk("irq", rirq, 1'b1);
		rx(8'h3C, 8);
		chk("ovr", ovr, 1'b1);
		chk("buf", rbuf, 8'h3C);
		rdp();
		disc = 1'b1;
		rx(8'h96, 8);
		chk("strip", rirq, 1'b0);
		chk("buf", rbuf, 8'h96);
		rdp();
		disc = 1'b0;
		u_p.send(4'h5, 4);
		srch = 1'b0;
		step(2);
		chk("drop", act, 1'b0);
		srch = 1'b1;
		rx(4'hA, 4);
		chk("lost", rdone, 1'b0);
		one = 1'b1;
		// buffer still holds the stripped sync char
		toggle();
		chk("false", act, 1'b1);
		rdp();
		rx(8'h55, 8);
		toggle();
		chk("pad", act, 1'b0);
		rx({8'h3C, 8'h96}, 16);
		chk("one", act, 1'b1);
		chk("buf", rbuf, 8'h3C);
		srch = 1'b0;
		mode = line_rx_pkg::MODE_EXT_SYNC;
		clen = 2'h0;
		rdp();
		srch = 1'b1;
		step(3);
		chk("ext", act, 1'b1);
		rx(5'h13, 5);
		chk("ext", rbuf, 8'h13);
		srch = 1'b0;
		mode = line_rx_pkg::MODE_ISO;
		clen = 2'h3;
		rdp();
		srch = 1'b1;
		step(3);
		chk("iso", act, 1'b1);
		rx({1'b1, 8'hC6, 1'b0}, 10);
		chk("iso", rbuf, 8'hC6);
		chk("fe", fe, 1'b0);
		rdp();
		rx({1'b0, 8'h39, 1'b0}, 10);
		chk("fe", fe, 1'b1);
		rdp();
		twr = 1'b1;
		for (k = 0; k < 9; k++) begin
			twd = 8'hA0 + 8'(k);
			n += int'(trdy);
			step();
		end
		twr = 1'b0;
		chk("fill", 8'(n), 8'h08);
		txen = 1'b1;
		txie = 1'b1;
		run = 1'b1;
		for (k = 0; k < 8; k++) begin
			u_p.grab(8, c, stp);
			chk("tx", c, 8'hA0 + 8'(k));
			chk("stop", stp, 1'b1);
		end
		step();
		chk("tdone", tdone, 1'b1);
		chk("tirq", tirq, 1'b1);
		chk("idle", txd, 1'b1);
		twd = 8'h5A;
		twr = 1'b1;
		step();
		twr = 1'b0;
		chk("rewrite", tdone, 1'b0);
		u_p.grab(8, c, stp);
		chk("tx", c, 8'h5A);
		step();
		txen = 1'b0;
		step();
		chk("txoff", tdone, 1'b0);
		mrst = 1'b1;
		step();
		mrst = 1'b0;
		chk("mrst", sch, 8'hFF);
		chk("mrst", act, 1'b0);
		end_of_test();
	end
endmodule : test_sync_iso_line_receiver
